/* File: rtl/tcoc_defines.svh */
`ifndef TCOC_DEFINES_SVH
`define TCOC_DEFINES_SVH

// Register byte offsets
`define TCOC_OFS_CH1_CFG   8'h44
`define TCOC_OFS_CH2_CFG   8'h48
`define TCOC_OFS_CH3_CFG   8'h4C
`define TCOC_OFS_CHAN_EN   8'h50
`define TCOC_OFS_CMP1      8'h60
`define TCOC_OFS_CMP2      8'h64
`define TCOC_OFS_CMP3      8'h68
`define TCOC_OFS_ASYM1     8'h70
`define TCOC_OFS_ASYM2     8'h74
`define TCOC_OFS_ASYM3     8'h78
`define TCOC_OFS_STATUS    8'h7C

// Output configuration fields
`define TCOC_MODE_HI_BIT   8
`define TCOC_IMAE_BIT      5
`define TCOC_PRE_BIT       4
`define TCOC_CFG_MASK      32'h0000_0137
`define TCOC_EN_MASK       32'h0000_0777

// Reset values
`define TCOC_CFG_RST       32'h0000_0000
`define TCOC_EN_RST        32'h0000_0000
`define TCOC_CMP_RST       16'h0000

`endif

/* File: rtl/tcoc_pkg.sv */
package tcoc_pkg;

  // Output mode encodings
  typedef enum logic [3:0] {
    TCOC_OM_HOLD   = 4'h0,
    TCOC_OM_CLR    = 4'h1,
    TCOC_OM_SET    = 4'h2,
    TCOC_OM_TOG    = 4'h3,
    TCOC_OM_FLO    = 4'h4,
    TCOC_OM_FHI    = 4'h5,
    TCOC_OM_PWM1   = 4'h6,
    TCOC_OM_PWM2   = 4'h7,
    TCOC_OM_APWM1  = 4'hE,
    TCOC_OM_APWM2  = 4'hF
  } tcoc_mode_t;

  // Per-channel configuration
  typedef struct packed {
    logic [3:0] mode;
    logic       imae;
    logic       pre;
  } tcoc_cfg_t;

  // Shared counter status from the time base
  typedef struct packed {
    logic [15:0] count;
    logic        down;
    logic        wrap;
    logic        update;
    logic        trigger;
  } tcoc_cnt_t;

endpackage

/* File: rtl/tcoc_chan.sv */
`timescale 1ns/1ns
`default_nettype none

// One compare channel: reference generation
module tcoc_chan (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // Configuration and counter
  input  wire tcoc_pkg::tcoc_cfg_t i_cfg,
  input  wire tcoc_pkg::tcoc_cnt_t i_cnt,
  input  wire logic [15:0]       i_cmp,
  input  wire logic [15:0]       i_asym,
  // Reference out
  output logic                   o_ref,
  output logic                   o_pulse
);

  logic ref_q;
  logic next_ref;
  logic pulse_q;
  logic next_pulse;
  logic is_pwm;
  logic match;
  logic up_lt;
  logic dn_gt;

  // Compare terms
  assign match  = (i_cnt.count == i_cmp);
  assign up_lt  = (i_cnt.count < i_cmp);
  assign is_pwm = (i_cfg.mode == tcoc_pkg::TCOC_OM_PWM1) ||
                  (i_cfg.mode == tcoc_pkg::TCOC_OM_PWM2);

  // Next reference level
  always_comb begin
    next_ref   = ref_q;
    next_pulse = pulse_q;
    dn_gt      = (i_cnt.count > i_cmp);
    // [RQ11] PWM-only pulse
    if (!is_pwm || !i_cfg.imae) begin
      next_pulse = 1'b0;
    // [RQ9] trigger starts pulse
    end else if (i_cnt.trigger) begin
      next_pulse = 1'b1;
    // [RQ10] wrap ends pulse
    end else if (i_cnt.wrap) begin
      next_pulse = 1'b0;
    end
    case (i_cfg.mode)
      // [RQ2] match actions
      tcoc_pkg::TCOC_OM_HOLD: next_ref = ref_q;
      tcoc_pkg::TCOC_OM_CLR:  if (match) next_ref = 1'b0;
      tcoc_pkg::TCOC_OM_SET:  if (match) next_ref = 1'b1;
      tcoc_pkg::TCOC_OM_TOG:  if (match) next_ref = ~ref_q;
      // [RQ3] forced levels
      tcoc_pkg::TCOC_OM_FLO:  next_ref = 1'b0;
      tcoc_pkg::TCOC_OM_FHI:  next_ref = 1'b1;
      // [RQ4] PWM mode 1
      tcoc_pkg::TCOC_OM_PWM1: next_ref = i_cnt.down ? !dn_gt : up_lt;
      // [RQ5] PWM mode 2
      tcoc_pkg::TCOC_OM_PWM2: next_ref = i_cnt.down ? dn_gt : !up_lt;
      // [RQ6] asymmetric mode 1
      tcoc_pkg::TCOC_OM_APWM1: next_ref = i_cnt.down ? !(i_cnt.count > i_asym) : up_lt;
      // [RQ7] asymmetric mode 2
      tcoc_pkg::TCOC_OM_APWM2: next_ref = i_cnt.down ? (i_cnt.count > i_asym) : !up_lt;
      default: next_ref = ref_q;
    endcase
    // [RQ9] matched level forced
    if (next_pulse) begin
      next_ref = (i_cfg.mode == tcoc_pkg::TCOC_OM_PWM1) ? 1'b1 : 1'b0;
    end
  end

  // Register state
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_q   <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      ref_q   <= next_ref;
      pulse_q <= next_pulse;
    end
  end

  assign o_ref   = ref_q;
  assign o_pulse = pulse_q;

  // [RQ3] forced low check
  a_force_low: assert property (@(posedge i_clk) disable iff (!i_rstn) // [RQ3]
    (i_cfg.mode == tcoc_pkg::TCOC_OM_FLO) |=> !ref_q)
    else $error("forced low mode left ref high");
  // [RQ3] forced high check
  a_force_high: assert property (@(posedge i_clk) disable iff (!i_rstn) // [RQ3]
    (i_cfg.mode == tcoc_pkg::TCOC_OM_FHI) |=> ref_q)
    else $error("forced high mode left ref low");
  // [RQ2] toggle check
  a_toggle_match: assert property (@(posedge i_clk) disable iff (!i_rstn) // [RQ2]
    (i_cfg.mode == tcoc_pkg::TCOC_OM_TOG && match) |=> (ref_q != $past(ref_q)))
    else $error("toggle on match missing");
  // [RQ2] hold check
  a_hold_level: assert property (@(posedge i_clk) disable iff (!i_rstn) // [RQ2]
    (i_cfg.mode == tcoc_pkg::TCOC_OM_HOLD) |=> $stable(ref_q))
    else $error("hold mode changed ref");
  // [RQ4] PWM1 up-count check
  a_pwm1_up: assert property (@(posedge i_clk) disable iff (!i_rstn) // [RQ4]
    (i_cfg.mode == tcoc_pkg::TCOC_OM_PWM1 && !i_cnt.down && !next_pulse)
    |=> (ref_q == $past(up_lt)))
    else $error("pwm1 up level wrong");
  // [RQ11] pulse only in PWM
  a_pulse_pwm: assert property (@(posedge i_clk) disable iff (!i_rstn) // [RQ11]
    pulse_q |-> $past(is_pwm))
    else $error("pulse outside pwm modes");
  // [RQ10] wrap ends pulse
  a_pulse_end: assert property (@(posedge i_clk) disable iff (!i_rstn) // [RQ10]
    (pulse_q && i_cnt.wrap && !i_cnt.trigger) |=> !pulse_q)
    else $error("pulse survived wrap");
  c_pulse: cover property (@(posedge i_clk) disable iff (!i_rstn) $rose(pulse_q));
  c_toggle: cover property (@(posedge i_clk) disable iff (!i_rstn)
    i_cfg.mode == tcoc_pkg::TCOC_OM_TOG && match);
  c_asym: cover property (@(posedge i_clk) disable iff (!i_rstn)
    i_cfg.mode == tcoc_pkg::TCOC_OM_APWM1 && i_cnt.down);

endmodule

`default_nettype wire

/* File: rtl/tcoc_cmp.sv */
`include "tcoc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

// Compare value with optional preload buffer
module tcoc_cmp (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // Write side
  input  wire logic        i_we,
  input  wire logic [15:0] i_data,
  input  wire logic        i_pre,
  input  wire logic        i_update,
  // Values
  output logic [15:0]      o_active,
  output logic [15:0]      o_shadow
);

  logic [15:0] act;
  logic [15:0] shd;
  logic [15:0] next_act;
  logic [15:0] next_shd;

  // [RQ12] preload or direct
  always_comb begin
    next_shd = i_we ? i_data : shd;
    next_act = act;
    if (!i_pre && i_we) begin
      next_act = i_data;
    end else if (i_pre && i_update) begin
      next_act = shd;
    end
  end

  // Register values
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      act <= `TCOC_CMP_RST;
      shd <= `TCOC_CMP_RST;
    end else begin
      act <= next_act;
      shd <= next_shd;
    end
  end

  assign o_active = act;
  assign o_shadow = shd;

  // [RQ12] direct write check
  a_direct_write: assert property (@(posedge i_clk) disable iff (!i_rstn) // [RQ12]
    (i_we && !i_pre) |=> (act == $past(i_data)))
    else $error("direct compare write lost");
  // [RQ12] preload holds
  a_preload_hold: assert property (@(posedge i_clk) disable iff (!i_rstn) // [RQ12]
    (i_pre && !i_update) |=> $stable(act))
    else $error("active changed without update");
  c_preload: cover property (@(posedge i_clk) disable iff (!i_rstn) i_pre && i_update);

endmodule

`default_nettype wire

/* File: rtl/tcoc_top.sv */
// The Wishbone slave port is this design's own decision.
`include "tcoc_defines.svh"
`timescale 1ns/1ns
`default_nettype none

// What this block does
// [RQ1] Four-bit output mode per channel, bit 8 and bits 2:0.
// [RQ2] On match: 0000 hold, 0001 low, 0010 high, 0011 toggle.
// [RQ3] Mode 0100 forces low, 0101 forces high.
// [RQ4] PWM1: up active below compare; down inactive above compare.
// [RQ5] PWM2: up inactive below compare; down active above compare.
// [RQ6] Asym PWM1: up like PWM1; down uses asymmetric compare.
// [RQ7] Asym PWM2: up like PWM2; down uses asymmetric compare.
// [RQ8] Software sets center-aligned counting before asymmetric modes.
// [RQ9] Bit 5 with trigger forces matched level at once.
// [RQ10] Immediate pulse ends at next overflow or underflow.
// [RQ11] Immediate pulse works only in PWM modes 0110 and 0111.
// [RQ12] Bit 4 preloads compare, moved at update event.
// [RQ13] Output channel enable routes reference to pin, gated by main enable.
// [RQ14] Input channel enable gates capture.
module tcoc_top (
  // Clock and reset
  input  wire logic        I_MCLK,
  input  wire logic        I_RSTN,
  // Wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [7:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic [31:0]      O_WB_DAT,
  output logic             O_WB_ACK,
  // Time base
  input  wire logic [15:0] I_COUNTER_VALUE,
  input  wire logic        I_COUNT_DOWN,
  input  wire logic        I_WRAP,
  input  wire logic        I_UPDATE,
  input  wire logic        I_TRIGGER,
  input  wire logic        I_MAIN_OUTPUT_ENABLE,
  input  wire logic [2:0]  I_DIRECTION_SELECT,
  // Channel outputs
  output logic [2:0]       O_CHAN_OUT,
  output logic [2:0]       O_CAPTURE_EN
);

  logic [31:0]         cfg_reg [3];
  logic [31:0]         next_cfg [3];
  logic [31:0]         en_reg;
  logic [31:0]         next_en;
  logic [31:0]         rd_data;
  logic [31:0]         next_dat;
  logic                next_ack;
  logic                ack_q;
  logic [31:0]         dat_q;
  logic [2:0]          out_q;
  logic [2:0]          next_out;
  logic [2:0]          cap_q;
  logic [2:0]          next_cap;
  logic [2:0]          chan_ref;
  logic [2:0]          chan_pulse;
  logic [2:0]          cmp_we;
  logic [2:0]          asym_we;
  logic [15:0]         cmp_act [3];
  logic [15:0]         cmp_shd [3];
  logic [15:0]         asym_act [3];
  logic [15:0]         asym_shd [3];
  logic                wr;
  tcoc_pkg::tcoc_cfg_t cfg [3];
  tcoc_pkg::tcoc_cnt_t cnt;

  // Write data merged under byte lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r & mask;
  endfunction

  // Counter status bundle
  assign cnt = '{count: I_COUNTER_VALUE, down: I_COUNT_DOWN, wrap: I_WRAP,
                 update: I_UPDATE, trigger: I_TRIGGER};
  assign wr  = I_WB_CYC && I_WB_STB && I_WB_WE && !ack_q;

  // Write strobes for compare values
  assign cmp_we[0]  = wr && (I_WB_ADR == `TCOC_OFS_CMP1);
  assign cmp_we[1]  = wr && (I_WB_ADR == `TCOC_OFS_CMP2);
  assign cmp_we[2]  = wr && (I_WB_ADR == `TCOC_OFS_CMP3);
  assign asym_we[0] = wr && (I_WB_ADR == `TCOC_OFS_ASYM1);
  assign asym_we[1] = wr && (I_WB_ADR == `TCOC_OFS_ASYM2);
  assign asym_we[2] = wr && (I_WB_ADR == `TCOC_OFS_ASYM3);

  // Configuration writes
  always_comb begin
    next_cfg[0] = cfg_reg[0];
    next_cfg[1] = cfg_reg[1];
    next_cfg[2] = cfg_reg[2];
    next_en     = en_reg;
    if (wr) begin
      case (I_WB_ADR)
        `TCOC_OFS_CH1_CFG: next_cfg[0] = merge(cfg_reg[0], I_WB_DAT, I_WB_SEL, `TCOC_CFG_MASK);
        `TCOC_OFS_CH2_CFG: next_cfg[1] = merge(cfg_reg[1], I_WB_DAT, I_WB_SEL, `TCOC_CFG_MASK);
        `TCOC_OFS_CH3_CFG: next_cfg[2] = merge(cfg_reg[2], I_WB_DAT, I_WB_SEL, `TCOC_CFG_MASK);
        `TCOC_OFS_CHAN_EN: next_en = merge(en_reg, I_WB_DAT, I_WB_SEL, `TCOC_EN_MASK);
        default: next_en = en_reg;
      endcase
    end
  end

  // Read mux
  always_comb begin
    case (I_WB_ADR)
      `TCOC_OFS_CH1_CFG: rd_data = cfg_reg[0];
      `TCOC_OFS_CH2_CFG: rd_data = cfg_reg[1];
      `TCOC_OFS_CH3_CFG: rd_data = cfg_reg[2];
      `TCOC_OFS_CHAN_EN: rd_data = en_reg;
      `TCOC_OFS_CMP1:    rd_data = {16'h0000, cmp_shd[0]};
      `TCOC_OFS_CMP2:    rd_data = {16'h0000, cmp_shd[1]};
      `TCOC_OFS_CMP3:    rd_data = {16'h0000, cmp_shd[2]};
      `TCOC_OFS_ASYM1:   rd_data = {16'h0000, asym_shd[0]};
      `TCOC_OFS_ASYM2:   rd_data = {16'h0000, asym_shd[1]};
      `TCOC_OFS_ASYM3:   rd_data = {16'h0000, asym_shd[2]};
      `TCOC_OFS_STATUS:  rd_data = {26'h0, chan_pulse, chan_ref};
      default:           rd_data = 32'h0000_0000;
    endcase
  end

  // Bus answer: one wait cycle, ack for one cycle
  always_comb begin
    next_ack = I_WB_CYC && I_WB_STB && !ack_q;
    next_dat = (next_ack && !I_WB_WE) ? rd_data : 32'h0000_0000;
  end

  // Channel configuration unpack and pin gating
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      // [RQ1] mode bit layout
      cfg[c].mode = {cfg_reg[c][`TCOC_MODE_HI_BIT], cfg_reg[c][2:0]};
      cfg[c].imae = cfg_reg[c][`TCOC_IMAE_BIT];
      cfg[c].pre  = cfg_reg[c][`TCOC_PRE_BIT];
      // [RQ13] enable routes ref
      next_out[c] = en_reg[c*4] && !I_DIRECTION_SELECT[c] &&
                    I_MAIN_OUTPUT_ENABLE && chan_ref[c];
      // [RQ14] enable gates capture
      next_cap[c] = en_reg[c*4] && I_DIRECTION_SELECT[c];
    end
  end

  // Register bank and outputs
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cfg_reg[0] <= `TCOC_CFG_RST;
      cfg_reg[1] <= `TCOC_CFG_RST;
      cfg_reg[2] <= `TCOC_CFG_RST;
      en_reg     <= `TCOC_EN_RST;
      ack_q      <= 1'b0;
      dat_q      <= 32'h0000_0000;
      out_q      <= 3'h0;
      cap_q      <= 3'h0;
    end else begin
      cfg_reg[0] <= next_cfg[0];
      cfg_reg[1] <= next_cfg[1];
      cfg_reg[2] <= next_cfg[2];
      en_reg     <= next_en;
      ack_q      <= next_ack;
      dat_q      <= next_dat;
      out_q      <= next_out;
      cap_q      <= next_cap;
    end
  end

  assign O_WB_ACK     = ack_q;
  assign O_WB_DAT     = dat_q;
  assign O_CHAN_OUT   = out_q;
  assign O_CAPTURE_EN = cap_q;

  // Per-channel compare storage and reference logic
  for (genvar g = 0; g < 3; g++) begin : g_chan
    tcoc_cmp u_cmp (
      .i_clk    (I_MCLK),
      .i_rstn   (I_RSTN),
      .i_we     (cmp_we[g]),
      .i_data   (I_WB_DAT[15:0]),
      .i_pre    (cfg[g].pre),
      .i_update (I_UPDATE),
      .o_active (cmp_act[g]),
      .o_shadow (cmp_shd[g])
    );
    tcoc_cmp u_asym (
      .i_clk    (I_MCLK),
      .i_rstn   (I_RSTN),
      .i_we     (asym_we[g]),
      .i_data   (I_WB_DAT[15:0]),
      .i_pre    (cfg[g].pre),
      .i_update (I_UPDATE),
      .o_active (asym_act[g]),
      .o_shadow (asym_shd[g])
    );
    tcoc_chan u_chan (
      .i_clk   (I_MCLK),
      .i_rstn  (I_RSTN),
      .i_cfg   (cfg[g]),
      .i_cnt   (cnt),
      .i_cmp   (cmp_act[g]),
      .i_asym  (asym_act[g]),
      .o_ref   (chan_ref[g]),
      .o_pulse (chan_pulse[g])
    );
  end

  // [RQ13] disabled output low
  a_out_disabled: assert property (@(posedge I_MCLK) disable iff (!I_RSTN) // [RQ13]
    !en_reg[0] |=> !out_q[0])
    else $error("disabled channel drove pin");
  // [RQ13] enabled output follows
  a_out_follow: assert property (@(posedge I_MCLK) disable iff (!I_RSTN) // [RQ13]
    (en_reg[4] && !I_DIRECTION_SELECT[1] && I_MAIN_OUTPUT_ENABLE) |=> out_q[1] == $past(chan_ref[1]))
    else $error("enabled output not following ref");
  // [RQ14] capture enable
  a_capture_en: assert property (@(posedge I_MCLK) disable iff (!I_RSTN) // [RQ14]
    (I_DIRECTION_SELECT[2] && en_reg[8]) |=> cap_q[2])
    else $error("capture not enabled");
  // Bus ack single cycle
  a_ack_pulse: assert property (@(posedge I_MCLK) disable iff (!I_RSTN)
    ack_q |=> !ack_q)
    else $error("ack held two cycles");
  c_write: cover property (@(posedge I_MCLK) disable iff (!I_RSTN) wr);

endmodule

`default_nettype wire

/* File: verif/tcoc_tbase_model.sv */
`timescale 1ns/1ns
`default_nettype none

// Center-aligned time base in front of the compare channels
module tcoc_tbase_model #(
  parameter int TOP = 12
) (
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rstn,
  // Counter stalls while low
  input  wire logic   i_run,
  // Counter status
  output logic [15:0] o_count,
  output logic        o_down,
  output logic        o_wrap,
  output logic        o_update
);
  logic at_end;

  // Turning point: top while rising, zero while falling
  assign at_end   = o_down ? (o_count == 16'h0000) : (o_count == 16'(TOP));
  assign o_wrap   = i_run & at_end;
  assign o_update = o_wrap;

  // Center-aligned counting only
  // Asymmetric modes therefore always see both count phases
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_count <= 16'h0000;
      o_down  <= 1'b0;
    end else if (i_run) begin
      o_down  <= at_end ? ~o_down : o_down;
      o_count <= (o_down ^ at_end) ? o_count - 16'h0001 : o_count + 16'h0001;
    end
  end
endmodule

`default_nettype wire

/* File: verif/tcoc_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "tcoc_defines.svh"

module timer_channel_output_compare_tb_top;
  localparam int TOP = 12;
  localparam logic [7:0] OFS [11] = '{8'h44, 8'h48, 8'h4C, 8'h50, 8'h60, 8'h64, 8'h68,
                                      8'h70, 8'h74, 8'h78, 8'h7C};
  localparam logic [3:0] MODES [10] = '{4'h5, 4'h1, 4'h2, 4'h3, 4'h0, 4'h4, 4'h6, 4'h7,
                                        4'hE, 4'hF};
  // Bus, time base and pins
  logic        clk, rst_n, cyc, we, run, trig, moe, wb_ack, down, wrap, upd;
  logic [7:0]  adr;
  logic [31:0] wdat, wb_rdat, q, seed;
  logic [15:0] cnt;
  logic [2:0]  dir, chan_out, cap_en;
  int          error_cnt = 0, total_checks = 0, cycles = 0, ch;
  // Reference model state
  logic [3:0]  m_mode [3];
  logic [15:0] m_act [3], m_sh [3], m_asa [3], m_ass [3];
  logic [11:0] m_en;
  logic [2:0]  m_imae, m_pre, m_ref, m_pul, m_out, m_cap;

  // Design and time base
  tcoc_top dut (
    .I_MCLK(clk), .I_RSTN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(cyc), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(wb_rdat), .O_WB_ACK(wb_ack),
    .I_COUNTER_VALUE(cnt), .I_COUNT_DOWN(down), .I_WRAP(wrap), .I_UPDATE(upd),
    .I_TRIGGER(trig), .I_MAIN_OUTPUT_ENABLE(moe), .I_DIRECTION_SELECT(dir),
    .O_CHAN_OUT(chan_out), .O_CAPTURE_EN(cap_en));
  tcoc_tbase_model #(.TOP(TOP)) partner (
    .i_clk(clk), .i_rstn(rst_n), .i_run(run), .o_count(cnt), .o_down(down),
    .o_wrap(wrap), .o_update(upd));

  // Clock at 10 MHz
  always #50 clk = ~clk;

  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction

  // Configuration word builder
  function automatic logic [31:0] cfgw(input logic [3:0] m, input logic ia, input logic pr);
    cfgw = {23'h0, m[3], 2'h0, ia, pr, 1'b0, m[2:0]};
  endfunction

  // Expected reference level for one cycle
  function automatic logic ref_fn(input logic [3:0] m, input logic [15:0] c, input logic dn,
                                  input logic [15:0] cp, input logic [15:0] as, input logic cur);
    case (m)
      4'h1: ref_fn = (c == cp) ? 1'b0 : cur;
      4'h2: ref_fn = (c == cp) ? 1'b1 : cur;
      4'h3: ref_fn = (c == cp) ? ~cur : cur;
      4'h4: ref_fn = 1'b0;
      4'h5: ref_fn = 1'b1;
      4'h6: ref_fn = dn ? (c <= cp) : (c < cp);
      4'h7: ref_fn = dn ? (c > cp) : (c >= cp);
      4'hE: ref_fn = dn ? (c <= as) : (c < cp);
      4'hF: ref_fn = dn ? (c > as) : (c >= cp);
      default: ref_fn = cur;
    endcase
  endfunction

  // Reference model, stepped on the same edges as the design
  always @(posedge clk or negedge rst_n) begin : model
    logic np;
    logic tk;
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        m_mode[i] <= 4'h0;
        m_act[i]  <= 16'h0000;
        m_sh[i]   <= 16'h0000;
        m_asa[i]  <= 16'h0000;
        m_ass[i]  <= 16'h0000;
      end
      {m_imae, m_pre, m_ref, m_pul, m_out, m_cap} <= 18'h00000;
      m_en <= 12'h000;
    end else begin
      tk = cyc & we & ~wb_ack;
      for (int i = 0; i < 3; i++) begin
        np = m_imae[i] & (m_mode[i] == 4'h6 || m_mode[i] == 4'h7) & (trig | (m_pul[i] & ~wrap));
        m_pul[i] <= np;
        m_ref[i] <= np ? (m_mode[i] == 4'h6)
                       : ref_fn(m_mode[i], cnt, down, m_act[i], m_asa[i], m_ref[i]);
        m_out[i] <= m_ref[i] & m_en[4 * i] & moe & ~dir[i];
        m_cap[i] <= m_en[4 * i] & dir[i];
        if (upd && m_pre[i]) begin
          m_act[i] <= m_sh[i];
          m_asa[i] <= m_ass[i];
        end
        if (tk && adr == OFS[i]) begin
          m_mode[i] <= {wdat[8], wdat[2:0]};
          m_imae[i] <= wdat[5];
          m_pre[i]  <= wdat[4];
        end
        if (tk && adr == OFS[i + 4]) begin
          m_sh[i] <= wdat[15:0];
          if (!m_pre[i]) m_act[i] <= wdat[15:0];
        end
        if (tk && adr == OFS[i + 7]) begin
          m_ass[i] <= wdat[15:0];
          if (!m_pre[i]) m_asa[i] <= wdat[15:0];
        end
      end
      if (tk && adr == OFS[3]) m_en <= wdat[11:0] & 12'h777;
    end
  end

  // Compare tasks
  task automatic check_bits(input logic [2:0] got, input logic [2:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (wb_ack !== 1'b1);
    q = wb_rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask

  // Every register reads zero
  task automatic reset_check();
    for (int i = 0; i < 11; i++) begin
      wb(1'b0, OFS[i], 32'h0);
      check_word(q, 32'h0000_0000, "reset value");
    end
  endtask

  // Pins and capture enables follow the model every cycle
  always @(negedge clk) begin
    check_bits(chan_out, m_out, "pin");
    check_bits(chan_out & ~dir, m_out & ~dir, "output pin");
    check_bits(cap_en, m_cap, "capture enable");
  end

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: timeout", $time);
      summarize();
    end
  end

  // Main sequence
  initial begin
    {clk, rst_n, cyc, we, run, trig, moe} = 7'h00;
    {adr, wdat, dir} = 43'h0;
    seed = 32'h130E;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    reset_check();
    for (int i = 0; i < 10; i++) wb(1'b1, OFS[i], 32'hFFFF_FFFF);
    for (int i = 0; i < 10; i++) begin
      wb(1'b0, OFS[i], 32'h0);
      check_word(q, (i < 3) ? 32'h137 : (i == 3) ? 32'h777 : 32'hFFFF, "mask");
    end
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    check_word(q, 32'h0000_0000, "unmapped read");
    for (int i = 0; i < 10; i++) wb(1'b1, OFS[i], 32'h0);
    $display("TEST registers done");
    moe <= 1'b1;
    run <= 1'b1;
    seed = lfsr(seed);
    wb(1'b1, `TCOC_OFS_CHAN_EN, 32'h0000_0111);
    wb(1'b1, `TCOC_OFS_CMP1, {28'h0, seed[3:0]});
    wb(1'b1, `TCOC_OFS_CMP3, 32'(TOP));
    wb(1'b1, `TCOC_OFS_ASYM1, {28'h0, seed[7:4]});
    wb(1'b1, `TCOC_OFS_ASYM2, 32'(TOP));
    for (int k = 0; k < 10; k++) begin
      for (int i = 0; i < 3; i++) wb(1'b1, OFS[i], cfgw(MODES[k], 1'b0, 1'b0));
      repeat (60) @(posedge clk);
    end
    $display("TEST output modes done");
    wb(1'b1, `TCOC_OFS_CMP1, 32'h0);
    wb(1'b1, `TCOC_OFS_CMP3, 32'h10);
    wb(1'b1, OFS[0], cfgw(4'h6, 1'b1, 1'b0));
    wb(1'b1, OFS[1], cfgw(4'h7, 1'b1, 1'b0));
    wb(1'b1, OFS[2], cfgw(4'h2, 1'b1, 1'b0));
    while (!(cnt == 16'h0002 && !down)) @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check_bits(chan_out & 3'h3, 3'h1, "forced level");
    // Status shows pulse on channels 1 and 2 with their forced levels
    wb(1'b0, `TCOC_OFS_STATUS, 32'h0);
    check_word(q & 32'h0000_003B, 32'h0000_0019, "pulse status");
    while (wrap !== 1'b1) @(posedge clk);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check_bits(chan_out & 3'h3, 3'h2, "pulse end");
    $display("TEST immediate pulse done");
    for (int i = 0; i < 3; i++) wb(1'b1, OFS[i], cfgw(4'h6, 1'b0, i == 1));
    wb(1'b1, `TCOC_OFS_CMP2, 32'h0000_0007);
    wb(1'b0, `TCOC_OFS_CMP2, 32'h0);
    check_word(q, 32'h0000_0007, "preload read");
    repeat (30) @(posedge clk);
    $display("TEST preload done");
    dir <= 3'h5;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check_bits(cap_en, 3'h5, "capture on");
    check_bits(chan_out & 3'h5, 3'h0, "input pins quiet");
    dir <= 3'h0;
    $display("TEST direction done");
    for (int n = 0; n < 400; n++) begin
      seed = lfsr(seed);
      ch = seed[9:8] % 3;
      case (seed[2:0])
        3'h0: wb(1'b1, OFS[ch], cfgw(MODES[seed[15:12] % 10], 1'b0, ch == 1));
        3'h1: wb(1'b1, OFS[ch + 4], {28'h0, seed[19:16]});
        3'h2: wb(1'b1, OFS[ch + 7], {28'h0, seed[19:16]});
        3'h3: wb(1'b1, OFS[3], {20'h0, seed[31:20]});
        3'h4: {moe, dir} <= {seed[20], seed[23:21]};
        3'h5: trig <= ~trig;
        3'h6: run <= seed[24] | seed[25];
        default: repeat (seed[28:24]) @(posedge clk);
      endcase
      @(posedge clk);
    end
    $display("TEST random traffic done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    reset_check();
    $display("TEST second reset done");
    summarize();
  end
endmodule

`default_nettype wire
